// ---- four_level_interrupt_controller.v ----
// Four-level interrupt controller top with special-function registers
`timescale 1ns/1ps
`default_nettype none
`include "flic_consts.vh"
// Notes on behaviour
// - Arbitrate external, timer, serial, counter, CAN, CAN timer, converter and SPI sources.
// - A source reaches arbitration only while its own enable bit is set.
// - Clearing bit 7 of the main enable register blocks every source.
// - Each source gets level 0 to 3 from its high and low level bits.
// - Service is preempted only by a strictly higher level.
// - A level 3 routine is never preempted.
// - Of simultaneous requests the higher level wins.
// - Equal levels are settled by fixed polling order, external 0 first, SPI last.
// - Each source has its fixed vector address.
// - CAN request is the OR of four CAN events; vector 003Bh, rank 8.
// - CAN timer overflow is its own request; vector 004Bh, rank 10.
// - Main enable bits 6..0: counter, timer2, serial, timer1, ext1, timer0, ext0.
// - Main enable register resets to zero and allows single-bit set and clear.
// - Second enable register holds SPI, CAN timer, converter, CAN in bits 3..0.
// - Second level-low register holds four low level bits, reset zero.
module four_level_interrupt_controller
(
  input wire i_sys_clk,
  input wire i_rst_n,
  // Register port
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_rd,
  output reg [7:0] o_sfr_rdata,
  input wire i_bit_wr,
  input wire [7:0] i_bit_addr,
  input wire i_bit_val,
  // Sources
  input wire i_ext_request_line_0,
  input wire i_ext_request_line_1,
  input wire i_timer0_overflow_flag,
  input wire i_timer1_overflow_flag,
  input wire i_timer2_overflow_flag,
  input wire i_counter_array_flag,
  input wire [4:0] i_compare_channel_flags,
  input wire i_uart_rx_flag,
  input wire i_uart_tx_flag,
  input wire i_can_tx_done_flag,
  input wire i_can_rx_done_flag,
  input wire i_can_error_flag,
  input wire i_buffer_overrun_flag,
  input wire i_converter_done_flag,
  input wire i_can_timer_overflow_flag,
  input wire i_spi_flag,
  // Core handshake
  input wire i_irq_ack,
  input wire i_reti,
  output reg o_irq_req,
  output reg [15:0] o_irq_vector,
  output reg [3:0] o_irq_source,
  output reg [1:0] o_irq_level,
  output reg [3:0] o_in_service
);
  localparam NSRC = `FLIC_NUM_SRC;
  localparam ST_IDLE = 1'b0;
  localparam ST_OFFER = 1'b1;

  // ==========================================
  // Registers
  reg [7:0] enable_main_r;
  reg [3:0] enable_ext_r;
  reg [6:0] level_low_a_r;
  reg [6:0] level_high_a_r;
  reg [3:0] level_low_b_r;
  reg [3:0] level_high_b_r;
  reg state_r;
  reg [1:0] ext0_sync_r;
  reg [1:0] ext1_sync_r;

  // ==========================================
  // Reorder register bits into polling order
  function [10:0] flic_order;
    input [6:0] main_bits;
    input [3:0] ext_bits;
    begin
      flic_order = {ext_bits[3], ext_bits[2], ext_bits[1], ext_bits[0], main_bits[5],
                    main_bits[4], main_bits[6], main_bits[3], main_bits[2], main_bits[1],
                    main_bits[0]};
    end
  endfunction

  // Bit write hitting a given bit-addressable register
  function bit_hit;
    input [7:0] baddr;
    input [7:0] base;
    begin
      bit_hit = (baddr[7:3] == base[7:3]);
    end
  endfunction

  // ==========================================
  // Source requests
  wire [NSRC-1:0] raw_req;
  wire can_req;
  wire uart_req;
  wire counter_req;
  wire [NSRC-1:0] src_enable;
  wire [NSRC-1:0] pending;
  wire [NSRC-1:0] lvl_high;
  wire [NSRC-1:0] lvl_low;

  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ext0_sync_r <= 2'h0;
      ext1_sync_r <= 2'h0;
    end
    else
    begin
      ext0_sync_r <= {ext0_sync_r[0], i_ext_request_line_0};
      ext1_sync_r <= {ext1_sync_r[0], i_ext_request_line_1};
    end
  end

  assign can_req = i_can_tx_done_flag | i_can_rx_done_flag | i_can_error_flag |
                   i_buffer_overrun_flag;
  assign uart_req = i_uart_rx_flag | i_uart_tx_flag;
  assign counter_req = i_counter_array_flag | (|i_compare_channel_flags);
  assign raw_req = {i_spi_flag,
                    i_can_timer_overflow_flag,
                    i_converter_done_flag,
                    can_req,
                    i_timer2_overflow_flag,
                    uart_req,
                    counter_req,
                    i_timer1_overflow_flag,
                    ext1_sync_r[1],
                    i_timer0_overflow_flag,
                    ext0_sync_r[1]};
  assign src_enable = flic_order(enable_main_r[6:0], enable_ext_r);
  assign pending = raw_req & src_enable & {NSRC{enable_main_r[`FLIC_GLOBAL_BIT]}};
  assign lvl_high = flic_order(level_high_a_r, level_high_b_r);
  assign lvl_low = flic_order(level_low_a_r, level_low_b_r);

  // ==========================================
  // Arbiter and in-service tracker
  wire win_valid;
  wire [3:0] win_index;
  wire [1:0] win_level;
  wire [15:0] win_vector;
  wire busy;
  wire [1:0] busy_level;
  wire [3:0] in_service;
  wire push;

  flic_arbiter #(
    .NUM_SRC(NSRC)
  ) u_arbiter (
    .i_pending(pending),
    .i_level_high(lvl_high),
    .i_level_low(lvl_low),
    .i_busy(busy),
    .i_busy_level(busy_level),
    .o_valid(win_valid),
    .o_index(win_index),
    .o_level(win_level),
    .o_vector(win_vector)
  );

  // A taken offer pushes its level into the tracker
  assign push = (state_r == ST_OFFER) && i_irq_ack;

  flic_service_stack u_stack (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_push(push),
    .i_push_level(o_irq_level),
    .i_pop(i_reti),
    .o_busy(busy),
    .o_level(busy_level),
    .o_in_service(in_service)
  );

  // ==========================================
  // Vector offer to the core
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= ST_IDLE;
      o_irq_req <= 1'b0;
      o_irq_vector <= 16'h0000;
      o_irq_source <= 4'h0;
      o_irq_level <= 2'h0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (win_valid && !i_reti)
          begin
            state_r <= ST_OFFER;
            o_irq_req <= 1'b1;
            o_irq_vector <= win_vector;
            o_irq_source <= win_index;
            o_irq_level <= win_level;
          end
        end
        ST_OFFER:
        begin
          if (i_irq_ack)
          begin
            state_r <= ST_IDLE;
            o_irq_req <= 1'b0;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          o_irq_req <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // In-service copy for the core
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_in_service <= 4'h0;
    else
      o_in_service <= in_service;
  end

  // ==========================================
  // Register writes, byte and single bit
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      enable_main_r <= `FLIC_RST_ENABLE_MAIN;
      enable_ext_r <= `FLIC_RST_ENABLE_EXT;
      level_low_a_r <= `FLIC_RST_LEVEL_A;
      level_high_a_r <= `FLIC_RST_LEVEL_A;
      level_low_b_r <= `FLIC_RST_LEVEL_B;
      level_high_b_r <= `FLIC_RST_LEVEL_B;
    end
    else if (i_sfr_wr)
    begin
      case (i_sfr_addr)
        `FLIC_ADDR_ENABLE_MAIN: enable_main_r <= i_sfr_wdata;
        `FLIC_ADDR_ENABLE_EXT: enable_ext_r <= i_sfr_wdata[3:0];
        `FLIC_ADDR_LEVEL_LOW_A: level_low_a_r <= i_sfr_wdata[6:0];
        `FLIC_ADDR_LEVEL_HIGH_A: level_high_a_r <= i_sfr_wdata[6:0];
        `FLIC_ADDR_LEVEL_LOW_B: level_low_b_r <= i_sfr_wdata[3:0];
        `FLIC_ADDR_LEVEL_HIGH_B: level_high_b_r <= i_sfr_wdata[3:0];
        default:
        begin
          enable_main_r <= enable_main_r;
        end
      endcase
    end
    else if (i_bit_wr)
    begin
      if (bit_hit(i_bit_addr, `FLIC_ADDR_ENABLE_MAIN))
      begin
        enable_main_r[i_bit_addr[2:0]] <= i_bit_val;
      end
      if (bit_hit(i_bit_addr, `FLIC_ADDR_ENABLE_EXT) && !i_bit_addr[2])
      begin
        enable_ext_r[i_bit_addr[1:0]] <= i_bit_val;
      end
      if (bit_hit(i_bit_addr, `FLIC_ADDR_LEVEL_LOW_A) && i_bit_addr[2:0] != 3'h7)
      begin
        level_low_a_r[i_bit_addr[2:0]] <= i_bit_val;
      end
      if (bit_hit(i_bit_addr, `FLIC_ADDR_LEVEL_LOW_B) && !i_bit_addr[2])
      begin
        level_low_b_r[i_bit_addr[1:0]] <= i_bit_val;
      end
    end
  end

  // ==========================================
  // Register reads, one cycle after the strobe
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sfr_rdata <= 8'h00;
    else if (i_sfr_rd)
    begin
      case (i_sfr_addr)
        `FLIC_ADDR_ENABLE_MAIN: o_sfr_rdata <= enable_main_r;
        `FLIC_ADDR_ENABLE_EXT: o_sfr_rdata <= {4'h0, enable_ext_r};
        `FLIC_ADDR_LEVEL_LOW_A: o_sfr_rdata <= {1'b0, level_low_a_r};
        `FLIC_ADDR_LEVEL_HIGH_A: o_sfr_rdata <= {1'b0, level_high_a_r};
        `FLIC_ADDR_LEVEL_LOW_B: o_sfr_rdata <= {4'h0, level_low_b_r};
        `FLIC_ADDR_LEVEL_HIGH_B: o_sfr_rdata <= {4'h0, level_high_b_r};
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule // four_level_interrupt_controller
`default_nettype wire

// ---- flic_consts.vh ----
// Constants of the four-level interrupt controller
`ifndef FLIC_CONSTS_VH
`define FLIC_CONSTS_VH
// ==========================================
// Register addresses
`define FLIC_ADDR_ENABLE_MAIN 8'hA8
`define FLIC_ADDR_ENABLE_EXT 8'hE8
`define FLIC_ADDR_LEVEL_LOW_A 8'hB8
`define FLIC_ADDR_LEVEL_HIGH_A 8'hB7
`define FLIC_ADDR_LEVEL_LOW_B 8'hF8
`define FLIC_ADDR_LEVEL_HIGH_B 8'hF7
// ==========================================
// Field positions and widths
`define FLIC_GLOBAL_BIT 7
`define FLIC_MAIN_SRC_W 7
`define FLIC_EXT_SRC_W 4
`define FLIC_NUM_SRC 11
// ==========================================
// Reset values
`define FLIC_RST_ENABLE_MAIN 8'h00
`define FLIC_RST_ENABLE_EXT 4'h0
`define FLIC_RST_LEVEL_A 7'h00
`define FLIC_RST_LEVEL_B 4'h0
// ==========================================
// Vector addresses, in polling order
`define FLIC_VEC_EXT0 16'h0003
`define FLIC_VEC_TIMER0 16'h000B
`define FLIC_VEC_EXT1 16'h0013
`define FLIC_VEC_TIMER1 16'h001B
`define FLIC_VEC_COUNTER 16'h0033
`define FLIC_VEC_UART 16'h0023
`define FLIC_VEC_TIMER2 16'h002B
`define FLIC_VEC_CANBUS 16'h003B
`define FLIC_VEC_CONVERTER 16'h0043
`define FLIC_VEC_CAN_TIMER 16'h004B
`define FLIC_VEC_SPI 16'h0053
`endif

// ---- flic_arbiter.v ----
// Level and polling-order arbiter of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "flic_consts.vh"
module flic_arbiter
#(
  parameter NUM_SRC = `FLIC_NUM_SRC
)
(
  input wire [NUM_SRC-1:0] i_pending,
  input wire [NUM_SRC-1:0] i_level_high,
  input wire [NUM_SRC-1:0] i_level_low,
  input wire i_busy,
  input wire [1:0] i_busy_level,
  output reg o_valid,
  output reg [3:0] o_index,
  output reg [1:0] o_level,
  output reg [15:0] o_vector
);
  // ==========================================
  // Vector lookup
  function [15:0] flic_vector;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: flic_vector = `FLIC_VEC_EXT0;
        4'h1: flic_vector = `FLIC_VEC_TIMER0;
        4'h2: flic_vector = `FLIC_VEC_EXT1;
        4'h3: flic_vector = `FLIC_VEC_TIMER1;
        4'h4: flic_vector = `FLIC_VEC_COUNTER;
        4'h5: flic_vector = `FLIC_VEC_UART;
        4'h6: flic_vector = `FLIC_VEC_TIMER2;
        4'h7: flic_vector = `FLIC_VEC_CANBUS;
        4'h8: flic_vector = `FLIC_VEC_CONVERTER;
        4'h9: flic_vector = `FLIC_VEC_CAN_TIMER;
        4'hA: flic_vector = `FLIC_VEC_SPI;
        default: flic_vector = 16'h0000;
      endcase
    end
  endfunction

  // ==========================================
  // Highest level first, then lowest polling rank
  integer k;
  reg [1:0] lvl;
  always @*
  begin
    lvl = 2'h0;
    o_valid = 1'b0;
    o_index = 4'h0;
    o_level = 2'h0;
    for (k = NUM_SRC - 1; k >= 0; k = k - 1)
    begin
      lvl = {i_level_high[k], i_level_low[k]};
      if (i_pending[k] && (!i_busy || lvl > i_busy_level))
      begin
        if (!o_valid || lvl >= o_level)
        begin
          o_valid = 1'b1;
          o_index = k[3:0];
          o_level = lvl;
        end
      end
    end
    o_vector = flic_vector(o_index);
  end
endmodule // flic_arbiter
`default_nettype wire

// ---- flic_service_stack.v ----
// In-service level tracker of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module flic_service_stack
(
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_push,
  input wire [1:0] i_push_level,
  input wire i_pop,
  output wire o_busy,
  output reg [1:0] o_level,
  output wire [3:0] o_in_service
);
  reg [3:0] in_service_r;
  reg [3:0] in_service_nxt;

  // ==========================================
  // Top set bit is the level now in service
  always @*
  begin
    o_level = 2'h0;
    if (in_service_r[1])
      o_level = 2'h1;
    if (in_service_r[2])
      o_level = 2'h2;
    if (in_service_r[3])
      o_level = 2'h3;
  end
  assign o_busy = |in_service_r;
  assign o_in_service = in_service_r;

  // ==========================================
  // Return releases top level, grant adds one
  always @*
  begin
    in_service_nxt = in_service_r;
    if (i_pop)
      in_service_nxt[o_level] = 1'b0;
    if (i_push)
      in_service_nxt[i_push_level] = 1'b1;
  end

  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      in_service_r <= 4'h0;
    else
      in_service_r <= in_service_nxt;
  end
endmodule // flic_service_stack
`default_nettype wire

// ---- flic_core_model.sv ----
// CPU core model that fetches vectors and returns from routines
`timescale 1ns/1ps
`default_nettype none
module flic_core_model
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_irq_req,
  input wire logic [1:0] i_delay,
  input wire logic i_ret_cmd,
  output logic o_irq_ack,
  output logic o_reti
);
  logic [1:0] wait_r;
  // ==========================================
  // Fetch after a chosen delay, return on command
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_r <= 2'h0;
      o_irq_ack <= 1'b0;
      o_reti <= 1'b0;
    end
    else
    begin
      o_reti <= i_ret_cmd;
      if (o_irq_ack)
      begin
        o_irq_ack <= 1'b0;
        wait_r <= 2'h0;
      end
      else if (i_irq_req && wait_r == i_delay)
        o_irq_ack <= 1'b1;
      else if (i_irq_req)
        wait_r <= wait_r + 2'h1;
    end
  end
endmodule // flic_core_model
`default_nettype wire

// ---- flic_asserts.sv ----
// Concurrent checks for the four-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "flic_consts.vh"
module flic_asserts
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_bit_wr,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_val,
  input wire logic i_irq_ack,
  input wire logic i_reti,
  input wire logic o_irq_req,
  input wire logic [15:0] o_irq_vector,
  input wire logic [3:0] o_irq_source,
  input wire logic [1:0] o_irq_level,
  input wire logic [3:0] o_in_service
);
  localparam logic [15:0] VT [0:10] = '{`FLIC_VEC_EXT0, `FLIC_VEC_TIMER0, `FLIC_VEC_EXT1,
    `FLIC_VEC_TIMER1, `FLIC_VEC_COUNTER, `FLIC_VEC_UART, `FLIC_VEC_TIMER2, `FLIC_VEC_CANBUS,
    `FLIC_VEC_CONVERTER, `FLIC_VEC_CAN_TIMER, `FLIC_VEC_SPI};
  logic [7:0] main_r;
  logic [3:0] svc_r;
  logic [3:0] top_m;
  logic [3:0] svc_nxt;
  // ==========================================
  // Shadow of main enable and in-service levels
  assign top_m = svc_r[3] ? 4'h8 : svc_r[2] ? 4'h4 : svc_r[1] ? 4'h2 : {3'h0, svc_r[0]};
  assign svc_nxt = (i_reti ? svc_r & ~top_m : svc_r)
    | ((i_irq_ack && o_irq_req) ? 4'h1 << o_irq_level : 4'h0);
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      main_r <= 8'h00;
      svc_r <= 4'h0;
    end
    else
    begin
      svc_r <= svc_nxt;
      if (i_sfr_wr && i_sfr_addr == 8'hA8)
        main_r <= i_sfr_wdata;
      else if (i_bit_wr && i_bit_addr[7:3] == 5'h15)
        main_r[i_bit_addr[2:0]] <= i_bit_val;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_offer;
    o_irq_req && !i_irq_ack;
  endsequence
  sequence s_taken;
    o_irq_req && i_irq_ack;
  endsequence
  offer_hold_a: assert property (s_offer |=> o_irq_req && $stable(o_irq_vector)
    && $stable(o_irq_source) && $stable(o_irq_level)) else $error("offer moved");
  offer_drop_a: assert property (s_taken |=> !o_irq_req) else $error("offer kept");
  vector_map_a: assert property (o_irq_req |-> o_irq_source <= 4'hA
    && o_irq_vector == VT[o_irq_source]) else $error("wrong vector");
  level_gate_a: assert property ($rose(o_irq_req) |-> (4'h1 << o_irq_level) > top_m)
    else $error("no preemption right");
  top_level_a: assert property (svc_r[3] && !o_irq_req |=> !o_irq_req)
    else $error("level 3 preempted");
  svc_copy_a: assert property (1'b1 |=> o_in_service == $past(svc_r))
    else $error("in-service wrong");
  global_off_a: assert property (!main_r[7] && !o_irq_req |=> !o_irq_req)
    else $error("offer while off");
  read_main_a: assert property (i_sfr_rd && i_sfr_addr == 8'hA8
    |=> o_sfr_rdata == $past(main_r)) else $error("bad readback");
  rdata_hold_a: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("rdata moved");
  reset_clear_a: assert property ($rose(i_rst_n) |-> !o_irq_req && o_in_service == 4'h0)
    else $error("not clear");
endmodule // flic_asserts
bind four_level_interrupt_controller flic_asserts chk_u
(
  .i_sys_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata,
  .i_bit_wr, .i_bit_addr, .i_bit_val, .i_irq_ack, .i_reti, .o_irq_req, .o_irq_vector,
  .o_irq_source, .o_irq_level, .o_in_service
);
`default_nettype wire

// ---- four_level_interrupt_controller_tb.sv ----
// Self-checking testbench of the four-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "flic_consts.vh"
module four_level_interrupt_controller_tb;
  localparam logic [15:0] VT [0:10] = '{`FLIC_VEC_EXT0, `FLIC_VEC_TIMER0, `FLIC_VEC_EXT1,
    `FLIC_VEC_TIMER1, `FLIC_VEC_COUNTER, `FLIC_VEC_UART, `FLIC_VEC_TIMER2, `FLIC_VEC_CANBUS,
    `FLIC_VEC_CONVERTER, `FLIC_VEC_CAN_TIMER, `FLIC_VEC_SPI};
  localparam logic [7:0] RA [0:5] = '{8'hA8, 8'hE8, 8'hB8, 8'hF8, 8'hF7, 8'h10};
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] i_bit_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic i_bit_wr = 1'b0;
  logic i_bit_val = 1'b0;
  logic ret_cmd = 1'b0;
  logic [1:0] dly = 2'h0;
  logic [19:0] src = 20'h0;
  logic [31:0] seed = 32'h40;
  logic [1:0] lvl [0:10] = '{default: 2'h0};
  logic [7:0] o_sfr_rdata;
  logic [15:0] o_irq_vector;
  logic [3:0] o_irq_source;
  logic [3:0] o_in_service;
  logic [1:0] o_irq_level;
  logic o_irq_req;
  logic i_irq_ack;
  logic i_reti;
  int n_fail = 0;
  int compares = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  four_level_interrupt_controller dut_u
  (
    .i_sys_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata,
    .i_bit_wr, .i_bit_addr, .i_bit_val,
    .i_ext_request_line_0(src[0]), .i_ext_request_line_1(src[1]),
    .i_timer0_overflow_flag(src[2]), .i_timer1_overflow_flag(src[3]),
    .i_timer2_overflow_flag(src[4]), .i_counter_array_flag(src[5]),
    .i_compare_channel_flags(src[10:6]), .i_uart_rx_flag(src[11]), .i_uart_tx_flag(src[12]),
    .i_can_tx_done_flag(src[13]), .i_can_rx_done_flag(src[14]), .i_can_error_flag(src[15]),
    .i_buffer_overrun_flag(src[16]), .i_converter_done_flag(src[17]),
    .i_can_timer_overflow_flag(src[18]), .i_spi_flag(src[19]),
    .i_irq_ack, .i_reti, .o_irq_req, .o_irq_vector, .o_irq_source, .o_irq_level, .o_in_service
  );
  flic_core_model core_u
  (
    .i_sys_clk, .i_rst_n, .i_irq_req(o_irq_req), .i_delay(dly), .i_ret_cmd(ret_cmd),
    .o_irq_ack(i_irq_ack), .o_reti(i_reti)
  );
  // ==========================================
  // Expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [19:0] sbit(input int i, input logic [31:0] r);
    int b;
    case (i)
      0: b = 0;
      1: b = 2;
      2: b = 1;
      3: b = 3;
      4: b = r[0] ? 5 : 6 + r[3:1] % 5;
      5: b = 11 + r[0];
      6: b = 4;
      7: b = 13 + r[1:0];
      default: b = i + 9;
    endcase
    return 20'h1 << b;
  endfunction
  function automatic logic [10:0] pk(input logic [10:0] m);
    return {m[10:7], m[4], m[6], m[5], m[3:0]};
  endfunction
  function automatic int win(input logic [10:0] m);
    int w;
    w = -1;
    for (int i = 0; i < 11; i++)
      if (m[i] && (w < 0 || lvl[i] > lvl[w]))
        w = i;
    return w;
  endfunction
  // ==========================================
  // Bus and check tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic timeout();
    n_fail++;
    give_verdict();
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task automatic wr_bit(input logic [7:0] a, input logic v);
    @(posedge i_sys_clk);
    i_bit_addr <= a;
    i_bit_val <= v;
    i_bit_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_bit_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_sfr_rdata;
  endtask
  task automatic put(input logic [19:0] v);
    @(posedge i_sys_clk);
    src <= v;
  endtask
  task automatic ret(input logic [19:0] keep);
    @(posedge i_sys_clk);
    src <= src & keep;
    ret_cmd <= 1'b1;
    @(posedge i_sys_clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic quiet();
    repeat (8)
    begin
      @(negedge i_sys_clk);
      chk(16'(o_irq_req), 16'h0000);
    end
  endtask
  task automatic setup(input logic [10:0] en, input logic [19:0] s, input logic ga);
    logic [10:0] h;
    logic [10:0] l;
    logic [10:0] e;
    for (int i = 0; i < 11; i++)
    begin
      h[i] = lvl[i][1];
      l[i] = lvl[i][0];
    end
    e = pk(en);
    h = pk(h);
    l = pk(l);
    wr_reg(8'hA8, 8'h00);
    src <= s;
    dly <= 2'(rnd());
    wr_reg(8'hE8, {4'h0, e[10:7]});
    wr_reg(8'hB8, {1'b0, l[6:0]});
    wr_reg(8'hB7, {1'b0, h[6:0]});
    wr_reg(8'hF8, {4'h0, l[10:7]});
    wr_reg(8'hF7, {4'h0, h[10:7]});
    wr_reg(8'hA8, {ga, e[6:0]});
  endtask
  task automatic serve(input int s);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    while (o_irq_req !== 1'b1 && n < 30)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    if (o_irq_req !== 1'b1)
      timeout();
    chk(16'(o_irq_source), 16'(s));
    chk(16'(o_irq_level), 16'(lvl[s]));
    chk(o_irq_vector, VT[s]);
    n = 0;
    while (o_irq_req === 1'b1 && n < 30)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    if (o_irq_req === 1'b1)
      timeout();
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    logic [7:0] d;
    logic [10:0] m;
    logic [19:0] s;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    foreach (RA[k])
    begin
      rd_reg(RA[k], d);
      chk(16'(d), 16'h0000);
    end
    for (int b = 0; b < 8; b++)
      wr_bit(8'hA8 | 8'(b), 1'b1);
    rd_reg(8'hA8, d);
    chk(16'(d), 16'h00FF);
    wr_bit(8'hAB, 1'b0);
    rd_reg(8'hA8, d);
    chk(16'(d), 16'h00F7);
    wr_reg(8'hE8, 8'h0F);
    rd_reg(8'hE8, d);
    chk(16'(d), 16'h000F);
    wr_bit(8'hE9, 1'b0);
    wr_bit(8'hEC, 1'b1);
    rd_reg(8'hE8, d);
    chk(16'(d), 16'h000D);
    wr_bit(8'hFA, 1'b1);
    rd_reg(8'hF8, d);
    chk(16'(d), 16'h0004);
    for (int i = 0; i < 11; i++)
    begin
      setup(11'h1 << i, sbit(i, rnd()), 1'b1);
      serve(i);
      ret(20'h0);
    end
    s = 20'h0;
    for (int i = 0; i < 11; i++)
      s = s | sbit(i, rnd());
    setup(11'h7FD, sbit(1, 0), 1'b1);
    quiet();
    setup(11'h7FF, s, 1'b0);
    quiet();
    wr_bit(8'hAF, 1'b1);
    serve(0);
    ret(20'h0);
    repeat (24)
    begin
      m = 11'(rnd());
      m[rnd() % 11] = 1'b1;
      s = 20'h0;
      for (int i = 0; i < 11; i++)
      begin
        lvl[i] = 2'(rnd());
        if (m[i])
          s = s | sbit(i, rnd());
      end
      setup(11'h7FF, s, 1'b1);
      serve(win(m));
      ret(20'h0);
    end
    lvl = '{0: 2'h1, 1: 2'h1, 2: 2'h3, 3: 2'h2, default: 2'h0};
    setup(11'h00F, sbit(0, 0), 1'b1);
    serve(0);
    put(src | sbit(1, 0));
    quiet();
    put(src | sbit(2, 0));
    serve(2);
    repeat (2) @(negedge i_sys_clk);
    chk(16'(o_in_service), 16'h000A);
    put(src | sbit(3, 0));
    quiet();
    ret(sbit(1, 0) | sbit(3, 0));
    serve(3);
    ret(sbit(1, 0));
    quiet();
    ret(sbit(1, 0));
    serve(1);
    ret(20'h0);
    give_verdict();
  end
endmodule // four_level_interrupt_controller_tb
`default_nettype wire
